// file: hw/quad_uart_defines.svh
// register offsets, field positions, reset values and counts of the uart
`ifndef QUAD_UART_DEFINES_SVH
`define QUAD_UART_DEFINES_SVH

// per-channel register offsets, selected by the three address inputs
`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_EVT 3'h2
`define OFS_LCR 3'h3
`define OFS_MC 3'h4
`define OFS_LSR 3'h5
`define OFS_MSR 3'h6
`define OFS_SCR 3'h7

// event status and enable bit positions, same layout in both
`define EV_RX_ERR 0
`define EV_RX_DATA 1
`define EV_THRE 2
`define EV_MODEM 3

// modem_control_reg fields
`define MC_DTR 0
`define MC_RTS 1
`define MC_OUT1 2
`define MC_IRQ_OUTPUT_GATE 3
`define MC_LOOP 4

// line control and fifo control fields
`define LCR_DLAB 7
`define FCR_EN 0
`define FCR_RX_CLR 1
`define FCR_TX_CLR 2

// reset values
`define REG_RESET 8'h00
`define IER_RESET 4'h0
`define MC_RESET 5'h00
`define DIV_LO_RESET 8'h01
`define DIV_CNT_RESET 16'h0001

// four ten-bit character times in 16x ticks
`define TIMEOUT_TICKS 10'h280
// last 16x tick of a bit, and mid-bit for start check
`define SUB_LAST 4'hf
`define SUB_MID 4'h7
`define BIT_LAST 3'h7

`endif

// file: hw/quad_uart_pkg.sv
// shared types of the quad uart
package quad_uart_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [2:0] reg_addr_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b11,
    TX_STOP = 2'b10
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_e;

endpackage

// file: hw/uart_serial_engine.sv
// one channel's 8n1 serial shifter pair and 16x baud tick
`timescale 1ns/1ps
`include "quad_uart_defines.svh"

module uart_serial_engine (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // baud divisor
  input wire logic [15:0] i_divisor,
  // transmit side
  input wire logic i_tx_valid,
  input wire quad_uart_pkg::byte_t i_tx_data,
  output logic o_tx_take,
  output logic o_tx_busy,
  output logic o_serial_out,
  // receive side
  input wire logic i_serial_in,
  output logic o_rx_valid,
  output quad_uart_pkg::byte_t o_rx_data,
  output logic o_rx_frame_err,
  output logic o_tick
);
  import quad_uart_pkg::*;

  logic [15:0] div_cnt;
  tx_state_e tx_state;
  logic [3:0] tx_sub;
  logic [2:0] tx_bit;
  byte_t tx_shift;
  rx_state_e rx_state;
  logic [3:0] rx_sub;
  logic [2:0] rx_bit;
  byte_t rx_shift;

  // divisor of zero behaves as one
  assign o_tick = div_cnt <= `DIV_CNT_RESET;
  assign o_tx_busy = tx_state != TX_IDLE;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      div_cnt <= `DIV_CNT_RESET;
    end else if (o_tick) begin
      div_cnt <= i_divisor;
    end else begin
      div_cnt <= div_cnt - `DIV_CNT_RESET;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    o_tx_take <= 1'b0;
    if (i_sys_rst) begin
      tx_state <= TX_IDLE;
      tx_sub <= 4'h0;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      o_serial_out <= 1'b1;
    end else if (tx_state == TX_IDLE) begin
      if (i_tx_valid) begin
        tx_shift <= i_tx_data;
        o_tx_take <= 1'b1;
        o_serial_out <= 1'b0;
        tx_sub <= 4'h0;
        tx_state <= TX_START;
      end
    end else if (o_tick) begin
      tx_sub <= tx_sub + 4'h1;
      if (tx_sub == `SUB_LAST) begin
        case (tx_state)
          TX_START: begin
            o_serial_out <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bit <= 3'h0;
            tx_state <= TX_DATA;
          end
          TX_DATA: begin
            if (tx_bit == `BIT_LAST) begin
              o_serial_out <= 1'b1;
              tx_state <= TX_STOP;
            end else begin
              o_serial_out <= tx_shift[0];
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_bit <= tx_bit + 3'h1;
            end
          end
          default: tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // samples near mid-bit; a start shorter than half a bit is dropped
  always_ff @(posedge i_ref_clk) begin
    o_rx_valid <= 1'b0;
    if (i_sys_rst) begin
      rx_state <= RX_IDLE;
      rx_sub <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      o_rx_data <= 8'h00;
      o_rx_frame_err <= 1'b0;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_sub <= 4'h0;
          if (!i_serial_in) rx_state <= RX_START;
        end
        RX_START: if (o_tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == `SUB_MID) begin
            rx_sub <= 4'h0;
            rx_bit <= 3'h0;
            rx_state <= i_serial_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: if (o_tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == `SUB_LAST) begin
            rx_shift <= {i_serial_in, rx_shift[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == `BIT_LAST) rx_state <= RX_STOP;
          end
        end
        default: if (o_tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == `SUB_LAST) begin
            o_rx_valid <= 1'b1;
            o_rx_data <= rx_shift;
            o_rx_frame_err <= !i_serial_in;
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

endmodule // uart_serial_engine

// file: hw/quad_uart_pin_control.sv
// four-channel uart: host bus, registers, fifos, modem and interrupt pins
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "quad_uart_defines.svh"

// Summary of operation
// RQ1 - irq high for enabled pending sources only
// RQ2 - sources: rx error, rx data/timeout, thre, modem
// RQ3 - irq drops when serviced or on reset
// RQ4 - read strobe puts addressed register on bus
// RQ5 - write strobe stores bus into addressed register
// RQ6 - master reset clears registers, sets outputs; the divisor low byte dll resets to 01 instead
// RQ7 - reset disables serial output and input
// RQ8 - ring indicator shown in modem status bit 6
// RQ9 - rts control bit one drives rts low
// RQ10 - rts output high after reset
// RQ11 - rts never affects serial traffic
// RQ12 - loopback isolates input, feeds transmitter back
// RQ13 - rx ready low when receive fifo full
// RQ14 - tx ready low when transmit fifo full
// RQ15 - serial output marks high on reset
// RQ16 - per-channel select gates that channel's accesses
// RQ17 - irq pin floats unless gate bit or force input set
// RQ18 - force input enables every irq pin
// RQ19 - identical channels share only bus, clock, reset and force input
module quad_uart_pin_control #(
  parameter int CHANNELS = 4,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // host bus
  input wire logic [CHANNELS-1:0] i_channel_select_n,
  input wire quad_uart_pkg::reg_addr_t i_addr,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire quad_uart_pkg::byte_t i_data,
  output quad_uart_pkg::byte_t o_data,
  output logic o_data_oe,
  // interrupts
  input wire logic i_irq_force_enable,
  output logic [CHANNELS-1:0] o_channel_irq_out,
  output logic [CHANNELS-1:0] o_channel_irq_out_oe,
  // serial lines
  input wire logic [CHANNELS-1:0] i_serial_in,
  output logic [CHANNELS-1:0] o_serial_out,
  // modem lines
  input wire logic [CHANNELS-1:0] i_clear_to_send_n,
  input wire logic [CHANNELS-1:0] i_data_set_ready_n,
  input wire logic [CHANNELS-1:0] i_ring_indicator_in_n,
  input wire logic [CHANNELS-1:0] i_carrier_detect_n,
  output logic [CHANNELS-1:0] o_request_to_send_out_n,
  output logic [CHANNELS-1:0] o_terminal_ready_n,
  // transfer handshakes
  output logic [CHANNELS-1:0] o_rx_transfer_ready,
  output logic [CHANNELS-1:0] o_tx_transfer_ready
);
  import quad_uart_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = PW + 1;
  localparam int SW = 5 * CHANNELS + 1;
  localparam logic [SW-1:0] SYNC_RST = {1'b0, {(SW - 1){1'b1}}};

  // without fifo mode each fifo holds a single character
  function automatic logic fifo_full(input logic [CW-1:0] cnt,
                                     input logic en);
    fifo_full = en ? (cnt == CW'(FIFO_DEPTH)) : (cnt != '0);
  endfunction

  generate
    if (CHANNELS < 1 || FIFO_DEPTH < 2 ||
        (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad
      $error("FIFO_DEPTH must be a power of two of at least 2");
    end
  endgenerate

  // serial, modem and force input pins pass two flops; the host bus pins do not
  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  logic [CHANNELS-1:0] rx_s;
  logic [CHANNELS-1:0] cts_s;
  logic [CHANNELS-1:0] dsr_s;
  logic [CHANNELS-1:0] ri_s;
  logic [CHANNELS-1:0] dcd_s;
  logic force_s;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pin_meta <= SYNC_RST;
      pin_sync <= SYNC_RST;
    end else begin
      pin_meta <= {i_irq_force_enable, i_carrier_detect_n,
                   i_ring_indicator_in_n, i_data_set_ready_n,
                   i_clear_to_send_n, i_serial_in};
      pin_sync <= pin_meta;
    end
  end

  assign rx_s = pin_sync[CHANNELS-1:0];
  assign cts_s = pin_sync[2*CHANNELS-1:CHANNELS];
  assign dsr_s = pin_sync[3*CHANNELS-1:2*CHANNELS];
  assign ri_s = pin_sync[4*CHANNELS-1:3*CHANNELS];
  assign dcd_s = pin_sync[5*CHANNELS-1:4*CHANNELS];
  assign force_s = pin_sync[SW-1];

  // host bus decode
  logic [CHANNELS-1:0] rd_hit;
  logic [CHANNELS-1:0] wr_hit;
  logic [CHANNELS-1:0][7:0] rd_val;

  assign rd_hit = ~i_channel_select_n & {CHANNELS{~i_read_strobe_n}}; // RQ16
  assign wr_hit = ~i_channel_select_n & {CHANNELS{~i_write_strobe_n}}; // RQ16

  // data stand one cycle after the strobe; lowest selected channel wins
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_data_oe <= |rd_hit; // RQ4
      o_data <= 8'h00;
      for (int k = CHANNELS - 1; k >= 0; k--) begin
        if (rd_hit[k]) o_data <= rd_val[k]; // RQ4
      end
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch // RQ19
    logic rd;
    logic wr;
    logic dlab;
    logic loop;
    logic [3:0] ier;
    logic [3:0] ev;
    logic [3:0] next_ev;
    logic [3:0] ev_set;
    logic [3:0] msr_now;
    logic [3:0] msr_prev;
    logic [3:0] msr_delta;
    logic [3:0] msr_chg;
    logic [4:0] modem_control_reg;
    byte_t lcr;
    byte_t scr;
    byte_t dll;
    byte_t dlm;
    byte_t rv;
    logic fifo_en;
    logic overrun;
    logic frame_err;
    byte_t rx_mem [FIFO_DEPTH];
    byte_t tx_mem [FIFO_DEPTH];
    logic [PW-1:0] rx_wp;
    logic [PW-1:0] rx_rp;
    logic [PW-1:0] tx_wp;
    logic [PW-1:0] tx_rp;
    logic [CW-1:0] rx_cnt;
    logic [CW-1:0] tx_cnt;
    logic rx_push;
    logic rx_pop;
    logic rx_clr;
    logic tx_push;
    logic tx_pop;
    logic tx_clr;
    logic fcr_wr;
    logic rx_full;
    logic tx_full;
    logic timeout_hit;
    logic [9:0] idle_ticks;
    logic line_in;
    logic eng_tick;
    logic eng_rx_valid;
    logic eng_frame;
    logic eng_tx_out;
    logic eng_busy;
    byte_t eng_rx_data;
    logic irq_q;
    logic irq_oe_q;
    logic tx_pin;
    logic rts_n;
    logic dtr_n;
    logic rx_rdy;
    logic tx_rdy;

    assign rd = rd_hit[c];
    assign wr = wr_hit[c];
    assign dlab = lcr[`LCR_DLAB];
    assign loop = modem_control_reg[`MC_LOOP];
    assign rx_full = fifo_full(rx_cnt, fifo_en);
    assign tx_full = fifo_full(tx_cnt, fifo_en);
    assign fcr_wr = wr && i_addr == `OFS_EVT;

    // the pin is cut off in loopback; rts takes no part here
    assign line_in = loop ? eng_tx_out : rx_s[c]; // RQ12 RQ11

    // held in reset, the engine neither sends nor receives
    uart_serial_engine u_engine (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst), // RQ7
      .i_divisor({dlm, dll}),
      .i_tx_valid(tx_cnt != '0),
      .i_tx_data(tx_mem[tx_rp]),
      .o_tx_take(tx_pop),
      .o_tx_busy(eng_busy),
      .o_serial_out(eng_tx_out),
      .i_serial_in(line_in),
      .o_rx_valid(eng_rx_valid),
      .o_rx_data(eng_rx_data),
      .o_rx_frame_err(eng_frame),
      .o_tick(eng_tick)
    );

    // a full fifo drops the write or the character
    assign rx_push = eng_rx_valid && !rx_full;
    assign rx_pop = rd && !dlab && i_addr == `OFS_DATA && rx_cnt != '0;
    assign tx_push = wr && !dlab && i_addr == `OFS_DATA && !tx_full;
    assign rx_clr = fcr_wr &&
      (i_data[`FCR_RX_CLR] || i_data[`FCR_EN] != fifo_en);
    assign tx_clr = fcr_wr &&
      (i_data[`FCR_TX_CLR] || i_data[`FCR_EN] != fifo_en);

    always_ff @(posedge i_ref_clk) begin
      if (rx_push) rx_mem[rx_wp] <= eng_rx_data;
      if (tx_push) tx_mem[tx_wp] <= i_data;
    end

    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || rx_clr) begin
        rx_wp <= '0;
        rx_rp <= '0;
        rx_cnt <= '0;
      end else begin
        if (rx_push) rx_wp <= rx_wp + 1'b1;
        if (rx_pop) rx_rp <= rx_rp + 1'b1;
        rx_cnt <= rx_cnt + CW'(rx_push) - CW'(rx_pop);
      end
    end

    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || tx_clr) begin
        tx_wp <= '0;
        tx_rp <= '0;
        tx_cnt <= '0;
      end else begin
        if (tx_push) tx_wp <= tx_wp + 1'b1;
        if (tx_pop) tx_rp <= tx_rp + 1'b1;
        tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
      end
    end

    // control registers
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin // RQ6
        ier <= `IER_RESET;
        lcr <= `REG_RESET;
        scr <= `REG_RESET;
        dll <= `DIV_LO_RESET;
        dlm <= `REG_RESET;
        modem_control_reg <= `MC_RESET;
        fifo_en <= 1'b0;
      end else if (wr) begin // RQ5
        case (i_addr)
          `OFS_DATA: if (dlab) dll <= i_data;
          `OFS_IER: begin
            if (dlab) dlm <= i_data;
            else ier <= i_data[3:0];
          end
          `OFS_EVT: fifo_en <= i_data[`FCR_EN];
          `OFS_LCR: lcr <= i_data;
          `OFS_MC: modem_control_reg <= i_data[4:0];
          `OFS_SCR: scr <= i_data;
          default: ;
        endcase
      end
    end

    // line errors: cleared by a status read, a new error wins
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        overrun <= 1'b0;
        frame_err <= 1'b0;
      end else begin
        if (rd && i_addr == `OFS_LSR) begin
          overrun <= 1'b0;
          frame_err <= 1'b0;
        end
        if (eng_rx_valid && rx_full) overrun <= 1'b1;
        if (eng_rx_valid && eng_frame) frame_err <= 1'b1;
      end
    end

    // modem status, active high; loopback reads the control bits
    assign msr_now = loop ?
      {modem_control_reg[`MC_IRQ_OUTPUT_GATE],
       modem_control_reg[`MC_OUT1],
       modem_control_reg[`MC_DTR],
       modem_control_reg[`MC_RTS]} :
      ~{dcd_s[c], ri_s[c], dsr_s[c], cts_s[c]}; // RQ8
    // ring reports only its trailing edge
    assign msr_chg = {msr_prev[3] ^ msr_now[3],
                      msr_prev[2] & ~msr_now[2],
                      msr_prev[1] ^ msr_now[1],
                      msr_prev[0] ^ msr_now[0]};

    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        msr_prev <= 4'h0;
        msr_delta <= 4'h0;
      end else begin
        msr_prev <= msr_now;
        msr_delta <= ((rd && i_addr == `OFS_MSR) ? 4'h0 : msr_delta)
                     | msr_chg;
      end
    end

    // character timeout, restarted by any receive fifo traffic
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || rx_cnt == '0 || rx_push || rx_pop) begin
        idle_ticks <= 10'h000;
      end else if (eng_tick && idle_ticks != `TIMEOUT_TICKS) begin
        idle_ticks <= idle_ticks + 10'h001;
      end
    end

    assign timeout_hit = fifo_en && eng_tick && rx_cnt != '0 &&
                         idle_ticks == `TIMEOUT_TICKS - 10'h001;

    // sticky events; reading them services the channel
    assign ev_set[`EV_RX_ERR] = eng_rx_valid && (rx_full || eng_frame); // RQ2
    assign ev_set[`EV_RX_DATA] = rx_push || timeout_hit; // RQ2
    assign ev_set[`EV_THRE] = tx_pop && !tx_push &&
                              tx_cnt == CW'(1); // RQ2
    assign ev_set[`EV_MODEM] = |msr_chg; // RQ2
    assign next_ev = ((rd && i_addr == `OFS_EVT) ? 4'h0 : ev)
                     | ev_set; // RQ3

    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        ev <= 4'h0; // RQ3
      end else begin
        ev <= next_ev;
      end
    end

    // pin flops
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        irq_q <= 1'b0; // RQ3
        irq_oe_q <= 1'b0;
        tx_pin <= 1'b1; // RQ15 RQ7
        rts_n <= 1'b1; // RQ10
        dtr_n <= 1'b1;
        rx_rdy <= 1'b1;
        tx_rdy <= 1'b1;
      end else begin
        irq_q <= |(next_ev & ier); // RQ1
        irq_oe_q <= force_s ||
          modem_control_reg[`MC_IRQ_OUTPUT_GATE]; // RQ17 RQ18
        // loopback keeps the line marking
        tx_pin <= loop || eng_tx_out;
        rts_n <= !modem_control_reg[`MC_RTS]; // RQ9
        dtr_n <= !modem_control_reg[`MC_DTR];
        rx_rdy <= !rx_full; // RQ13
        tx_rdy <= !tx_full; // RQ14
      end
    end

    assign o_channel_irq_out[c] = irq_q;
    assign o_channel_irq_out_oe[c] = irq_oe_q;
    assign o_serial_out[c] = tx_pin;
    assign o_request_to_send_out_n[c] = rts_n;
    assign o_terminal_ready_n[c] = dtr_n;
    assign o_rx_transfer_ready[c] = rx_rdy;
    assign o_tx_transfer_ready[c] = tx_rdy;

    // register read view; empty fifo reads as zero
    always_comb begin
      case (i_addr)
        `OFS_DATA: begin
          if (dlab) rv = dll;
          else rv = (rx_cnt == '0) ? 8'h00 : rx_mem[rx_rp];
        end
        `OFS_IER: rv = dlab ? dlm : {4'h0, ier};
        `OFS_EVT: rv = {fifo_en, fifo_en, 2'b00, ev};
        `OFS_LCR: rv = lcr;
        `OFS_MC: rv = {3'h0, modem_control_reg};
        `OFS_LSR: rv = {1'b0, tx_cnt == '0 && !eng_busy, tx_cnt == '0,
                        1'b0, frame_err, 1'b0, overrun, rx_cnt != '0};
        `OFS_MSR: rv = {msr_now, msr_delta};
        default: rv = scr;
      endcase
    end

    assign rd_val[c] = rv;
  end

endmodule // quad_uart_pin_control

// file: sim/quad_uart_chk.sv
// port assertions of the quad uart pin control block
`timescale 1ns/1ps
`include "quad_uart_defines.svh"

module quad_uart_chk #(
  parameter int CHANNELS = 4
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // host bus
  input wire logic [CHANNELS-1:0] i_channel_select_n,
  input wire quad_uart_pkg::reg_addr_t i_addr,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire quad_uart_pkg::byte_t i_data,
  input wire quad_uart_pkg::byte_t o_data,
  input wire logic o_data_oe,
  // pins
  input wire logic i_irq_force_enable,
  input wire logic [CHANNELS-1:0] o_channel_irq_out,
  input wire logic [CHANNELS-1:0] o_channel_irq_out_oe,
  input wire logic [CHANNELS-1:0] o_serial_out,
  input wire logic [CHANNELS-1:0] o_request_to_send_out_n,
  input wire logic [CHANNELS-1:0] o_rx_transfer_ready,
  input wire logic [CHANNELS-1:0] o_tx_transfer_ready
);
  import quad_uart_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  logic rd_hit;
  assign rd_hit = !i_read_strobe_n && !(&i_channel_select_n);

  irq_reset_a: assert property (i_sys_rst |=> o_channel_irq_out == '0)
    else $error("irq not low after reset");
  tx_mark_a: assert property (i_sys_rst |=> &o_serial_out)
    else $error("serial out not marking in reset");
  rts_reset_a: assert property (i_sys_rst |=> &o_request_to_send_out_n)
    else $error("rts active after reset");
  ready_reset_a: assert property (i_sys_rst |=> &o_rx_transfer_ready
    && &o_tx_transfer_ready) else $error("ready low after reset");
  oe_reset_a: assert property (i_sys_rst |=> !o_data_oe
    && o_channel_irq_out_oe == '0) else $error("enable high in reset");
  // force pin reaches the irq enables three edges later: two sync flops and the pin flop
  force_oe_a: assert property (disable iff (i_sys_rst)
    i_irq_force_enable [*4] |=> &o_channel_irq_out_oe)
    else $error("force pin did not enable irq pins");
  read_answer_a: assert property (disable iff (i_sys_rst)
    rd_hit |=> o_data_oe) else $error("read not answered");
  read_idle_a: assert property (disable iff (i_sys_rst)
    !rd_hit |=> !o_data_oe && o_data == '0)
    else $error("bus driven without selected read");
  rts_write_a: assert property (disable iff (i_sys_rst)
    !i_write_strobe_n && !i_channel_select_n[0] && i_addr == `OFS_MC
    |=> ##1 o_request_to_send_out_n[0] == !$past(i_data[`MC_RTS], 2))
    else $error("rts pin does not follow control bit");

  cover property (disable iff (i_sys_rst) $rose(o_channel_irq_out[2]));
  cover property (disable iff (i_sys_rst) !o_rx_transfer_ready[3]);
  cover property (disable iff (i_sys_rst) $fell(o_request_to_send_out_n[1]));
endmodule // quad_uart_chk

bind quad_uart_pin_control quad_uart_chk #(.CHANNELS(CHANNELS)) chk (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_channel_select_n(i_channel_select_n), .i_addr(i_addr),
  .i_read_strobe_n(i_read_strobe_n), .i_write_strobe_n(i_write_strobe_n),
  .i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe),
  .i_irq_force_enable(i_irq_force_enable),
  .o_channel_irq_out(o_channel_irq_out),
  .o_channel_irq_out_oe(o_channel_irq_out_oe), .o_serial_out(o_serial_out),
  .o_request_to_send_out_n(o_request_to_send_out_n),
  .o_rx_transfer_ready(o_rx_transfer_ready),
  .o_tx_transfer_ready(o_tx_transfer_ready));

// file: sim/modem_far_end.sv
// far-end modem model: serial lines and ring pins of four channels
`timescale 1ns/1ps

module modem_far_end #(
  parameter int BIT_CYC = 16
) (
  // clock
  input wire logic i_ref_clk,
  // lines from the uart
  input wire logic [3:0] i_line,
  // lines to the uart
  output logic [3:0] o_line,
  output logic [3:0] o_ring_n
);
  initial begin
    o_line = 4'hf;
    o_ring_n = 4'hf;
  end
  task automatic set_ring(input int c, input logic v);
    @(posedge i_ref_clk);
    o_ring_n[c] <= v;
  endtask
  // used to show that an isolated input is ignored
  task automatic set_line(input int c, input logic v);
    @(posedge i_ref_clk);
    o_line[c] <= v;
  endtask
  // 8n1, lsb first, idle marking
  task automatic send(input int c, input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_ref_clk);
      o_line[c] <= f[i];
      repeat (BIT_CYC - 1) @(posedge i_ref_clk);
    end
  endtask
  // waits for a start bit, then samples each bit in its middle
  task automatic recv(input int c, output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    b = '0;
    while (i_line[c] !== 1'b0 && n < 400) begin
      @(posedge i_ref_clk);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge i_ref_clk);
    ok = (i_line[c] === 1'b0) && (n < 400);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge i_ref_clk);
      b[i] = i_line[c];
    end
    repeat (BIT_CYC) @(posedge i_ref_clk);
    ok = ok && (i_line[c] === 1'b1);
  endtask
endmodule // modem_far_end

// file: sim/quad_uart_pin_control_bench.sv
// self-checking bench of the quad uart pin control block
`timescale 1ns/1ps
`include "quad_uart_defines.svh"

`define CHK(nm, e, g) \
  checks_done++; \
  if ((g) !== (e)) begin \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
    bad_count++; \
  end

module quad_uart_pin_control_bench;
  import quad_uart_pkg::*;
  logic i_ref_clk = 0;
  logic i_sys_rst = 1;
  logic [3:0] sel_n = 4'hf;
  reg_addr_t addr = '0;
  logic rd_n = 1;
  logic wr_n = 1;
  byte_t wdata = '0;
  logic force_en = 0;
  byte_t rdata;
  logic rd_oe;
  logic [3:0] irq, irq_oe, ser_in, ser_out, rts_n, rx_rdy, tx_rdy, ring_n;
  logic [3:0] dtr_n;
  int bad_count = 0;
  int checks_done = 0;

  always #4 i_ref_clk = ~i_ref_clk;

  quad_uart_pin_control dut (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_channel_select_n(sel_n), .i_addr(addr), .i_read_strobe_n(rd_n),
    .i_write_strobe_n(wr_n), .i_data(wdata), .o_data(rdata),
    .o_data_oe(rd_oe), .i_irq_force_enable(force_en),
    .o_channel_irq_out(irq), .o_channel_irq_out_oe(irq_oe),
    .i_serial_in(ser_in), .o_serial_out(ser_out),
    .i_clear_to_send_n(4'hf), .i_data_set_ready_n(4'hf),
    .i_ring_indicator_in_n(ring_n), .i_carrier_detect_n(4'hf),
    .o_request_to_send_out_n(rts_n), .o_terminal_ready_n(dtr_n),
    .o_rx_transfer_ready(rx_rdy), .o_tx_transfer_ready(tx_rdy));

  modem_far_end mdm (.i_ref_clk(i_ref_clk), .i_line(ser_out),
    .o_line(ser_in), .o_ring_n(ring_n));

  function automatic logic exp_rts_n(input byte_t m);
    return !m[`MC_RTS];
  endfunction

  task automatic wr(input int c, input reg_addr_t a, input byte_t d);
    @(posedge i_ref_clk);
    sel_n <= ~(4'h1 << c);
    addr <= a;
    wdata <= d;
    wr_n <= 1'b0;
    @(posedge i_ref_clk);
    sel_n <= 4'hf;
    wr_n <= 1'b1;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input int c, input reg_addr_t a, output byte_t d);
    @(posedge i_ref_clk);
    sel_n <= ~(4'h1 << c);
    addr <= a;
    rd_n <= 1'b0;
    @(posedge i_ref_clk);
    sel_n <= 4'hf;
    rd_n <= 1'b1;
    #1 d = rdata;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    give_verdict;
  end

  initial begin
    byte_t d, m, gate;
    byte_t scr[4];
    byte_t q[18];
    bit ok;
    int seed;
    int n;
    seed = 99;
    gate = '0;
    repeat (4) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    #1;
    `CHK("rts after reset", 4'hf, rts_n)
    `CHK("tx marking", 4'hf, ser_out)
    `CHK("ready after reset", 8'hff, {rx_rdy, tx_rdy})
    $display("test reset done");
    scr[0] = 8'hff;
    wr(0, `OFS_SCR, scr[0]);
    for (int c = 1; c < 4; c++) begin
      scr[c] = byte_t'($random(seed));
      wr(c, `OFS_SCR, scr[c]);
    end
    for (int c = 0; c < 4; c++) begin
      rd(c, `OFS_SCR, d);
      `CHK("scratch", scr[c], d)
    end
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      m = byte_t'($random(seed)) & 8'h09;
      m[`MC_RTS] = c[0];
      gate[c] = m[`MC_IRQ_OUTPUT_GATE];
      wr(c, `OFS_MC, m);
      @(posedge i_ref_clk);
      #1;
      `CHK("rts pin", exp_rts_n(m), rts_n[c])
      `CHK("irq gate", m[`MC_IRQ_OUTPUT_GATE], irq_oe[c])
    end
    @(posedge i_ref_clk) force_en <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    #1 `CHK("forced irq pins", 4'hf, irq_oe)
    @(posedge i_ref_clk) force_en <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    #1 `CHK("gated irq pins", gate[3:0], irq_oe)
    $display("test modem control done");
    wr(2, `OFS_IER, 8'h00);
    mdm.set_ring(2, 1'b0);
    repeat (6) @(posedge i_ref_clk);
    rd(2, `OFS_MSR, d);
    `CHK("ring bit", 1'b1, d[6])
    mdm.set_ring(2, 1'b1);
    repeat (6) @(posedge i_ref_clk);
    #1 `CHK("masked irq", 1'b0, irq[2])
    rd(2, `OFS_MSR, d);
    `CHK("ring trailing edge", 1'b1, d[2])
    wr(2, `OFS_IER, 8'h01 << `EV_MODEM);
    repeat (2) @(posedge i_ref_clk);
    #1 `CHK("enabled irq", 1'b1, irq[2])
    rd(2, `OFS_EVT, d);
    `CHK("modem event", 1'b1, d[`EV_MODEM])
    @(posedge i_ref_clk);
    #1 `CHK("serviced irq", 1'b0, irq[2])
    $display("test interrupt done");
    m = byte_t'($random(seed));
    wr(1, `OFS_DATA, m);
    mdm.recv(1, d, ok);
    `CHK("tx frame", 1'b1, ok)
    `CHK("tx byte", m, d)
    m = byte_t'($random(seed));
    mdm.send(1, m);
    repeat (40) @(posedge i_ref_clk);
    rd(1, `OFS_DATA, d);
    `CHK("rx byte", m, d)
    $display("test serial done");
    wr(3, `OFS_EVT, 8'h01);
    wr(3, `OFS_MC, 8'h01 << `MC_LOOP);
    mdm.set_line(3, 1'b0);
    for (int i = 0; i < 18; i++) begin
      q[i] = byte_t'($random(seed));
      wr(3, `OFS_DATA, q[i]);
    end
    #1 `CHK("tx ready full", 1'b0, tx_rdy[3])
    n = 0;
    while (rx_rdy[3] !== 1'b0 && n < 4000) begin
      @(posedge i_ref_clk);
      n++;
    end
    #1 `CHK("rx ready full", 1'b0, rx_rdy[3])
    `CHK("loop pin marks", 1'b1, ser_out[3])
    for (int i = 0; i < 16; i++) begin
      rd(3, `OFS_DATA, d);
      `CHK("looped byte", q[i], d)
    end
    mdm.set_line(3, 1'b1);
    $display("test loopback done");
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    #1 `CHK("rts after reset", 8'hff, {rts_n, dtr_n})
    `CHK("irq pins after reset", 4'h0, irq_oe)
    rd(1, `OFS_MC, d);
    `CHK("control cleared", 8'h00, d)
    $display("test second reset done");
    give_verdict;
  end
endmodule // quad_uart_pin_control_bench
